// *** hdl/fpc_pkg.sv ***
// Constants, types and helpers shared by the field pair changeover monitor.
// Assumes a 250 MHz core clock and 32-bit APB register access.
package fpc_pkg;

  // Timing
  localparam int          CLOCK_HZ          = 250_000_000;
  localparam int          CYCLES_PER_MS     = CLOCK_HZ / 1000;
  localparam logic [15:0] SYNC_TIME_MS      = 16'h0028;
  localparam logic [15:0] MIN_CHG_TIME_MS   = 16'h0028;
  localparam logic [12:0] RESET_HOLD_MIN_MS = 13'h0078;
  localparam logic [12:0] RESET_HOLD_MAX_MS = 13'h0fa0;
  localparam logic [12:0] RESET_HOLD_SAT_MS = 13'h0fa1;
  localparam logic [11:0] CONTOUR_TOL_MM    = 12'h0c8;

  // Sizes
  localparam int NUM_FUNC  = 2;
  localparam int NUM_PAIRS = 10;
  localparam int SEL_W     = 5;
  localparam int FUNC_LANE = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_CHG_TIME   = 8'h04;
  localparam logic [7:0] ADDR_RESP_TIME  = 8'h08;
  localparam logic [7:0] ADDR_PAIR_EN    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_CMD        = 8'h14;
  localparam logic [7:0] ADDR_ORDER_BASE = 8'h40;
  localparam logic [7:0] ADDR_ORDER_LAST = 8'h64;

  // Control fields
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_START_IL    = 2;
  localparam int CTRL_RESTART_IL  = 3;
  localparam int CTRL_TWO_FUNC    = 4;
  localparam int CTRL_ORDER_EN    = 5;
  localparam int CTRL_CONTOUR_LSB = 6;
  localparam int CMD_CLR_FAULT    = 0;

  // Status fields
  localparam int ST_PAIR_A_LSB = 0;
  localparam int ST_PAIR_B_LSB = 4;
  localparam int ST_SAFETY_SWITCHING_OUTPUT_LSB   = 8;
  localparam int ST_IL_LSB     = 10;
  localparam int ST_FAULT_LSB  = 12;
  localparam int ST_BUSY_LSB   = 14;
  localparam int ST_CAUSE_LSB  = 16;

  // Fault cause bits, four per function
  localparam int CAUSE_TIMING  = 0;
  localparam int CAUSE_ORDER   = 1;
  localparam int CAUSE_CONFIG  = 2;
  localparam int CAUSE_CONTOUR = 3;

  // Reset values
  localparam logic [7:0]  CTRL_RESET      = 8'h0c;
  localparam logic [15:0] CHG_TIME_RESET  = 16'h0028;
  localparam logic [15:0] RESP_TIME_RESET = 16'h0000;
  localparam logic [31:0] PAIR_EN_RESET   = 32'h03ff_03ff;
  localparam logic [31:0] ORDER_RESET     = 32'h03ff_03ff;

  // Activation modes
  localparam logic [1:0] MODE_FIXED   = 2'h0;
  localparam logic [1:0] MODE_OVERLAP = 2'h1;
  localparam logic [1:0] MODE_MOMENT  = 2'h2;

  typedef enum logic [1:0] {
    CHG_IDLE = 2'b01,
    CHG_RUN  = 2'b10
  } fpc_chg_e;

  function automatic logic [9:0] pair_bit(input logic [3:0] idx);
    pair_bit = 10'h001 << idx;
  endfunction

endpackage

// *** hdl/fpc_sel_if.sv ***
// Select-input bundle between the monitor and its decoder.
// Assumes the select bits are already synchronised to the core clock.
`timescale 1ns/1ps
interface fpc_sel_if;
  logic [4:0] sel;
  logic [1:0] mode;
  logic [3:0] idx;
  logic       valid;
  logic [2:0] ones;
  logic [9:0] mask;

  modport decoder (input sel, input mode, output idx, output valid, output ones, output mask);
  modport user    (output sel, output mode, input idx, input valid, input ones, input mask);
endinterface

// *** hdl/fpc_select_decoder.sv ***
// Decodes five field-select inputs into a field pair for the active mode.
// Assumes synchronised inputs; purely combinational.
`timescale 1ns/1ps
module fpc_select_decoder (
  // Select bundle
  fpc_sel_if.decoder port
);

  function automatic logic [2:0] ones_of(input logic [4:0] v);
    ones_of = 3'h0;
    for (int i = 0; i < 5; i++) begin
      ones_of = ones_of + {2'h0, v[i]};
    end
  endfunction

  function automatic logic [2:0] pos_of(input logic [4:0] v);
    pos_of = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (v[i]) begin
        pos_of = 3'(i);
      end
    end
  endfunction

  always_comb begin
    port.ones  = ones_of(port.sel);
    port.idx   = 4'h0;
    port.valid = 1'b0;
    port.mask  = 10'h000;
    case (port.mode)
      fpc_pkg::MODE_FIXED: begin
        port.valid = 1'b1;
        port.mask  = fpc_pkg::pair_bit(4'h0);
      end
      fpc_pkg::MODE_OVERLAP: begin
        // Raw selects, each selected pair monitored
        port.mask = {5'h00, port.sel};
        if (port.ones == 3'h1) begin
          port.valid = 1'b1;
          port.idx   = {1'b0, pos_of(port.sel)};
        end
      end
      fpc_pkg::MODE_MOMENT: begin
        if (port.ones == 3'h1) begin
          port.valid = 1'b1;
          port.idx   = {1'b0, pos_of(port.sel)};
        end else if (port.ones == 3'h4) begin
          // Single low input selects pairs six to ten
          port.valid = 1'b1;
          port.idx   = 4'h9 - {1'b0, pos_of(~port.sel)};
        end
        port.mask = port.valid ? fpc_pkg::pair_bit(port.idx) : 10'h000;
      end
      default: begin
        port.valid = 1'b0;
      end
    endcase
  end

endmodule

// *** hdl/fpc_changeover_monitor.sv ***
// Field pair selection and changeover supervisor with APB registers.
// Assumes select pins and reset button are asynchronous; occupancy and
// contour inputs come from scanner logic on the same clock.
`timescale 1ns/1ps
module fpc_changeover_monitor #(
  parameter int CYCLES_PER_MS = fpc_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller pins
  input  wire logic [4:0]  field_select_in,
  input  wire logic [4:0]  field_select_b_in,
  input  wire logic        reset_button,
  // Scanner core
  input  wire logic [9:0]  pair_occupied_a,
  input  wire logic [9:0]  pair_occupied_b,
  input  wire logic [11:0] contour_dev_a_mm,
  input  wire logic [11:0] contour_dev_b_mm,
  // Safety outputs and status
  output logic [1:0]       safety_switching_output,
  output logic [1:0]       changeover_fault,
  output logic [1:0]       interlock_active,
  output logic [3:0]       active_pair_a,
  output logic [3:0]       active_pair_b
);

  localparam int NF = fpc_pkg::NUM_FUNC;

  // Pin synchronisers
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 11'h000;
      pin_sync <= 11'h000;
    end else begin
      pin_meta <= {reset_button, field_select_b_in, field_select_in};
      pin_sync <= pin_meta;
    end
  end

  // Millisecond tick
  logic [31:0] ms_cnt;
  logic        ms_tick;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == 32'(CYCLES_PER_MS - 1)) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // Reset button hold measurement
  logic        btn_q;
  logic [12:0] hold_ms;
  logic        reset_press;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      btn_q       <= 1'b0;
      hold_ms     <= 13'h0;
      reset_press <= 1'b0;
    end else begin
      btn_q       <= pin_sync[10];
      reset_press <= btn_q && !pin_sync[10] &&
                     hold_ms >= fpc_pkg::RESET_HOLD_MIN_MS &&
                     hold_ms <= fpc_pkg::RESET_HOLD_MAX_MS;
      if (!pin_sync[10]) begin
        hold_ms <= 13'h0;
      end else if (ms_tick && hold_ms != fpc_pkg::RESET_HOLD_SAT_MS) begin
        hold_ms <= hold_ms + 13'h1;
      end
    end
  end

  // Configuration registers
  logic [7:0]  ctrl;
  logic [15:0] chg_time;
  logic [15:0] resp_time;
  logic [31:0] pair_en;
  logic [31:0] order_tab [fpc_pkg::NUM_PAIRS];
  logic [15:0] chg_eff;

  // Per-function state visible to the bus; all but busy and cause also drive pins
  logic       safety_switching_output_q  [NF];
  logic       fault_q [NF];
  logic       il_q    [NF];
  logic       busy_q  [NF];
  logic [3:0] cause_q [NF];
  logic [3:0] active_q[NF];

  assign chg_eff = (chg_time < fpc_pkg::MIN_CHG_TIME_MS) ?
                   fpc_pkg::MIN_CHG_TIME_MS : chg_time;

  // APB slave
  logic        acc;
  logic        wr_en;
  logic        clr_fault;
  logic [31:0] rd_data;
  logic [3:0]  ord_idx;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) &&
              (a == fpc_pkg::ADDR_CTRL || a == fpc_pkg::ADDR_CHG_TIME ||
               a == fpc_pkg::ADDR_RESP_TIME || a == fpc_pkg::ADDR_PAIR_EN ||
               a == fpc_pkg::ADDR_STATUS || a == fpc_pkg::ADDR_CMD ||
               (a >= fpc_pkg::ADDR_ORDER_BASE && a <= fpc_pkg::ADDR_ORDER_LAST));
  endfunction

  assign acc       = psel && penable;
  assign wr_en     = acc && pready && pwrite && addr_ok(paddr);
  assign clr_fault = wr_en && paddr == fpc_pkg::ADDR_CMD && pwdata[fpc_pkg::CMD_CLR_FAULT];
  assign ord_idx   = 4'((paddr - fpc_pkg::ADDR_ORDER_BASE) >> 2);

  always_comb begin
    rd_data = 32'h0;
    if (paddr == fpc_pkg::ADDR_CTRL) begin
      rd_data[7:0] = ctrl;
    end else if (paddr == fpc_pkg::ADDR_CHG_TIME) begin
      rd_data[15:0] = chg_time;
    end else if (paddr == fpc_pkg::ADDR_RESP_TIME) begin
      rd_data[15:0] = resp_time;
    end else if (paddr == fpc_pkg::ADDR_PAIR_EN) begin
      rd_data = pair_en;
    end else if (paddr == fpc_pkg::ADDR_STATUS) begin
      rd_data[fpc_pkg::ST_PAIR_A_LSB +: 4] = active_q[0];
      rd_data[fpc_pkg::ST_PAIR_B_LSB +: 4] = active_q[1];
      rd_data[fpc_pkg::ST_SAFETY_SWITCHING_OUTPUT_LSB +: 2]   = {safety_switching_output_q[1], safety_switching_output_q[0]};
      rd_data[fpc_pkg::ST_IL_LSB +: 2]     = {il_q[1], il_q[0]};
      rd_data[fpc_pkg::ST_FAULT_LSB +: 2]  = {fault_q[1], fault_q[0]};
      rd_data[fpc_pkg::ST_BUSY_LSB +: 2]   = {busy_q[1], busy_q[0]};
      rd_data[fpc_pkg::ST_CAUSE_LSB +: 8]  = {cause_q[1], cause_q[0]};
    end else if (addr_ok(paddr) && paddr >= fpc_pkg::ADDR_ORDER_BASE) begin
      rd_data = order_tab[ord_idx];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      if (acc && !pready) begin
        prdata  <= rd_data;
        pslverr <= !addr_ok(paddr);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl      <= fpc_pkg::CTRL_RESET;
      chg_time  <= fpc_pkg::CHG_TIME_RESET;
      resp_time <= fpc_pkg::RESP_TIME_RESET;
      pair_en   <= fpc_pkg::PAIR_EN_RESET;
    end else if (wr_en) begin
      if (paddr == fpc_pkg::ADDR_CTRL) begin
        ctrl <= pwdata[7:0];
      end
      if (paddr == fpc_pkg::ADDR_CHG_TIME) begin
        chg_time <= pwdata[15:0];
      end
      if (paddr == fpc_pkg::ADDR_RESP_TIME) begin
        resp_time <= pwdata[15:0];
      end
      if (paddr == fpc_pkg::ADDR_PAIR_EN) begin
        pair_en <= pwdata;
      end
    end
  end

  for (genvar i = 0; i < fpc_pkg::NUM_PAIRS; i++) begin : g_order
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        order_tab[i] <= fpc_pkg::ORDER_RESET;
      end else if (wr_en && paddr >= fpc_pkg::ADDR_ORDER_BASE && ord_idx == 4'(i)) begin
        order_tab[i] <= pwdata;
      end
    end
  end

  // One supervisor per protective function
  for (genvar f = 0; f < NF; f++) begin : g_func
    fpc_sel_if sel_if ();

    logic [1:0]  mode;
    logic [9:0]  occ;
    logic [11:0] dev;
    logic [9:0]  pen;
    logic [9:0]  order_row;
    logic        fn_en;
    logic        order_bad;
    logic        expired;
    logic        viol;
    logic        cfg_bad;
    logic        contour_bad;
    logic [3:0]  set_cause;
    logic        set_timing;
    logic        set_order;
    fpc_pkg::fpc_chg_e state;
    logic [15:0] timer_ms;
    logic [4:0]  prev_sel;
    logic [9:0]  mon_mask;
    logic [9:0]  eval_mask;
    logic [9:0]  pending;
    logic [15:0] sync_ms;
    logic [15:0] resp_ms;
    logic        tripped;

    assign mode          = ctrl[fpc_pkg::CTRL_MODE_LSB +: 2];
    assign sel_if.sel    = pin_sync[fpc_pkg::SEL_W*f +: fpc_pkg::SEL_W];
    assign sel_if.mode   = mode;
    assign occ           = (f == 0) ? pair_occupied_a : pair_occupied_b;
    assign dev           = (f == 0) ? contour_dev_a_mm : contour_dev_b_mm;
    assign pen           = pair_en[fpc_pkg::FUNC_LANE*f +: fpc_pkg::NUM_PAIRS];
    assign order_row     = order_tab[active_q[f]][fpc_pkg::FUNC_LANE*f +: fpc_pkg::NUM_PAIRS];
    assign fn_en         = (f == 0) || ctrl[fpc_pkg::CTRL_TWO_FUNC];
    assign expired       = timer_ms >= chg_eff;
    assign order_bad     = ctrl[fpc_pkg::CTRL_ORDER_EN] &&
                           (!order_row[sel_if.idx] || !pen[sel_if.idx]);
    assign cfg_bad       = mode == 2'h3 ||
                           (mode == fpc_pkg::MODE_OVERLAP && |pen[9:5]);
    assign contour_bad   = ctrl[fpc_pkg::CTRL_CONTOUR_LSB + f] &&
                           dev > fpc_pkg::CONTOUR_TOL_MM;
    assign pending       = mon_mask & ~eval_mask;
    assign viol          = |(eval_mask & occ);

    fpc_select_decoder u_dec (
      .port (sel_if.decoder)
    );

    // Changeover sequencing
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        state       <= fpc_pkg::CHG_IDLE;
        timer_ms    <= 16'h0;
        prev_sel    <= 5'h00;
        mon_mask    <= 10'h001;
        active_q[f] <= 4'h0;
        set_timing  <= 1'b0;
        set_order   <= 1'b0;
      end else begin
        set_timing <= 1'b0;
        set_order  <= 1'b0;
        if (state == fpc_pkg::CHG_RUN && ms_tick && timer_ms != 16'hffff) begin
          timer_ms <= timer_ms + 16'h1;
        end
        case (mode)
          fpc_pkg::MODE_OVERLAP: begin
            mon_mask <= sel_if.mask;
            if (sel_if.ones > 3'h2) begin
              set_timing <= 1'b1;
            end
            unique case (state)
              fpc_pkg::CHG_IDLE: begin
                if (sel_if.ones != 3'h1 || sel_if.idx != active_q[f]) begin
                  state    <= fpc_pkg::CHG_RUN;
                  timer_ms <= 16'h0;
                end
              end
              fpc_pkg::CHG_RUN: begin
                if (sel_if.ones == 3'h1) begin
                  state       <= fpc_pkg::CHG_IDLE;
                  active_q[f] <= sel_if.idx;
                  set_order   <= order_bad;
                end else if (expired) begin
                  set_timing <= 1'b1;
                end
              end
            endcase
          end
          fpc_pkg::MODE_MOMENT: begin
            prev_sel <= sel_if.sel;
            if (sel_if.sel != prev_sel ||
                (state == fpc_pkg::CHG_IDLE && !sel_if.valid)) begin
              state    <= fpc_pkg::CHG_RUN;
              timer_ms <= 16'h0;
            end else if (state == fpc_pkg::CHG_RUN && expired) begin
              state <= fpc_pkg::CHG_IDLE;
              if (sel_if.valid) begin
                active_q[f] <= sel_if.idx;
                mon_mask    <= sel_if.mask;
                set_order   <= order_bad;
              end else begin
                set_timing <= 1'b1;
              end
            end
          end
          default: begin
            state       <= fpc_pkg::CHG_IDLE;
            active_q[f] <= 4'h0;
            mon_mask    <= fpc_pkg::pair_bit(4'h0);
          end
        endcase
      end
    end

    // Newly monitored pairs count only after the sync time
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        sync_ms   <= 16'h0;
        eval_mask <= 10'h001;
      end else begin
        if (pending == 10'h000) begin
          sync_ms <= 16'h0;
        end else if (ms_tick && sync_ms != 16'hffff) begin
          sync_ms <= sync_ms + 16'h1;
        end
        if (pending != 10'h000 && sync_ms >= fpc_pkg::SYNC_TIME_MS) begin
          eval_mask <= mon_mask;
        end else begin
          eval_mask <= eval_mask & mon_mask;
        end
      end
    end

    // Response time before a violation trips
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        resp_ms <= 16'h0;
        tripped <= 1'b0;
      end else begin
        if (!viol) begin
          resp_ms <= 16'h0;
        end else if (ms_tick && resp_ms != 16'hffff) begin
          resp_ms <= resp_ms + 16'h1;
        end
        tripped <= viol && (tripped || resp_ms >= resp_time);
      end
    end

    // Sticky fault; a new cause wins over a clear
    always_comb begin
      set_cause = 4'h0;
      if (fn_en) begin
        set_cause[fpc_pkg::CAUSE_TIMING]  = set_timing;
        set_cause[fpc_pkg::CAUSE_ORDER]   = set_order;
        set_cause[fpc_pkg::CAUSE_CONFIG]  = cfg_bad;
        set_cause[fpc_pkg::CAUSE_CONTOUR] = contour_bad;
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cause_q[f] <= 4'h0;
        fault_q[f] <= 1'b0;
      end else begin
        cause_q[f] <= (clr_fault ? 4'h0 : cause_q[f]) | set_cause;
        fault_q[f] <= (fault_q[f] && !clr_fault) || |set_cause;
      end
    end

    // Start and restart interlock
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        il_q[f] <= 1'b1;
      end else if (reset_press && !viol) begin
        il_q[f] <= 1'b0;
      end else if (tripped && ctrl[fpc_pkg::CTRL_RESTART_IL]) begin
        il_q[f] <= 1'b1;
      end else if (!ctrl[fpc_pkg::CTRL_START_IL] && !ctrl[fpc_pkg::CTRL_RESTART_IL]) begin
        il_q[f] <= 1'b0;
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        safety_switching_output_q[f] <= 1'b0;
        busy_q[f] <= 1'b0;
      end else begin
        safety_switching_output_q[f] <= fn_en && !fault_q[f] && !tripped && !il_q[f];
        busy_q[f] <= state == fpc_pkg::CHG_RUN;
      end
    end
  end

  assign safety_switching_output = {safety_switching_output_q[1], safety_switching_output_q[0]};
  assign changeover_fault        = {fault_q[1], fault_q[0]};
  assign interlock_active        = {il_q[1], il_q[0]};
  assign active_pair_a           = active_q[0];
  assign active_pair_b           = active_q[1];

endmodule

// *** testbench/fpc_changeover_monitor_properties.sv ***
// Port checker for the changeover monitor, bound to its top module.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
module fpc_monitor_properties (
  // Clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // APB
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  // Outputs
  input wire logic [1:0] safety_switching_output,
  input wire logic [1:0] changeover_fault,
  input wire logic [1:0] interlock_active,
  input wire logic [3:0] active_pair_a,
  input wire logic [3:0] active_pair_b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_fault_drops_a: assert property (changeover_fault[0] |=> !safety_switching_output[0])
    else $error("output A on while faulted");
  a_fault_drops_b: assert property (changeover_fault[1] |=> !safety_switching_output[1])
    else $error("output B on while faulted");
  a_fault_stays_set: assert property (changeover_fault[0]
    && !(pready && pwrite && paddr == fpc_pkg::ADDR_CMD) |=> changeover_fault[0])
    else $error("fault A cleared without command");
  a_interlock_keeps_off: assert property (interlock_active[0] |=> !safety_switching_output[0])
    else $error("output A on while interlocked");
  a_pair_a_range: assert property (active_pair_a <= 4'h9)
    else $error("pair A index out of range");
  a_pair_b_range: assert property (active_pair_b <= 4'h9)
    else $error("pair B index out of range");
  a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not after one wait state");
  a_bad_addr_err: assert property (pready && (paddr[1:0] != 2'h0
    || (paddr > 8'h14 && paddr < 8'h40) || paddr > 8'h64) |-> pslverr)
    else $error("no error on bad address");
endmodule

bind fpc_changeover_monitor fpc_monitor_properties u_props (
  .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .safety_switching_output(safety_switching_output), .changeover_fault(changeover_fault),
  .interlock_active(interlock_active), .active_pair_a(active_pair_a),
  .active_pair_b(active_pair_b)
);

// *** testbench/fpc_ctrl_model.sv ***
// Machine controller model driving the field-select pins.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/1ps
module fpc_ctrl_model (
  // Clock
  input wire logic       clock,
  // Select pins
  output logic     [4:0] sel_a,
  output logic     [4:0] sel_b
);
  initial begin
    sel_a = 5'h01;
    sel_b = 5'h01;
  end

  // Stable pattern held until the next call
  task automatic drive(input logic [4:0] a);
    @(posedge clock);
    sel_a <= a;
  endtask

  // Function B pattern held until the next call
  task automatic drive_b(input logic [4:0] b);
    @(posedge clock);
    sel_b <= b;
  endtask

  // New select first, old one dropped after the hold
  task automatic overlap(input logic [4:0] nxt, input int hold);
    @(posedge clock);
    sel_a <= sel_a | nxt;
    repeat (hold) @(posedge clock);
    sel_a <= nxt;
  endtask
endmodule

// *** testbench/test_field_pair_changeover_monitor.sv ***
// Self-checking bench for the field pair changeover monitor.
// Assumes a 10-cycle millisecond so every timer stays short.
`timescale 1ns/1ps
module test_field_pair_changeover_monitor;
  localparam int CPM = 10;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        reset_button = 1'b0;
  logic [9:0]  occ_a = 10'h000;
  logic [11:0] dev_a = 12'h000;
  logic [9:0]  occ_b = 10'h000;
  logic [11:0] dev_b = 12'h000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  sel_a;
  logic [4:0]  sel_b;
  logic [1:0]  ssp;
  logic [1:0]  fault;
  logic [1:0]  il;
  logic [3:0]  pair_a;
  logic [3:0]  pair_b;
  logic [31:0] q;
  logic        err;
  int          num_errors = 0;
  int          check_count = 0;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h64, 8'h20, 8'h02};
  logic [31:0] rv [8] = '{32'h0c, 32'h28, 32'h0, 32'h03ff_03ff, 32'h03ff_03ff,
                          32'h03ff_03ff, 32'h0, 32'h0};

  always #2 clock = ~clock;

  fpc_changeover_monitor #(.CYCLES_PER_MS(CPM)) dut (
    .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_select_in(sel_a), .field_select_b_in(sel_b), .reset_button(reset_button),
    .pair_occupied_a(occ_a), .pair_occupied_b(occ_b), .contour_dev_a_mm(dev_a),
    .contour_dev_b_mm(dev_b), .safety_switching_output(ssp), .changeover_fault(fault),
    .interlock_active(il), .active_pair_a(pair_a), .active_pair_b(pair_b)
  );
  fpc_ctrl_model ctrl (.clock(clock), .sel_a(sel_a), .sel_b(sel_b));

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; result left in q and err
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic press(input int ms);
    @(posedge clock);
    reset_button <= 1'b1;
    repeat (ms * CPM) @(posedge clock);
    reset_button <= 1'b0;
  endtask

  task automatic wait_out(input logic v, input int lim);
    int n;
    n = 0;
    while (ssp[0] !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, ssp[0]}, {31'h0, v});
  endtask

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(ra[i], 1'b0, 32'h0);
      check(q, rv[i]);
      check({31'h0, err}, {31'h0, i > 5});
    end
    check({30'h0, il}, 32'h3);
    press(50);
    repeat (50) @(posedge clock);
    check({31'h0, ssp[0]}, 32'h0);
    press(130);
    wait_out(1'b1, 50);
    occ_a <= 10'h001;
    wait_out(1'b0, 600);
    occ_a <= 10'h000;
    repeat (100) @(posedge clock);
    check({31'h0, ssp[0]}, 32'h0);
    press(130);
    wait_out(1'b1, 50);
    ctrl.drive(5'h04);
    repeat (500) @(posedge clock);
    check({28'h0, pair_a}, 32'h0);
    ctrl.drive(5'h01);
    apb(fpc_pkg::ADDR_CTRL, 1'b1, 32'h0d);
    repeat (2) @(posedge clock);
    check({30'h0, fault}, 32'h1);
    apb(fpc_pkg::ADDR_PAIR_EN, 1'b1, 32'h001f_001f);
    apb(fpc_pkg::ADDR_CMD, 1'b1, 32'h1);
    for (int i = 1; i < 5; i++) begin
      ctrl.overlap(5'h01 << i, 100);
      repeat (20) @(posedge clock);
      check({28'h0, pair_a}, 32'(i));
    end
    check({30'h0, fault}, 32'h0);
    ctrl.overlap(5'h01, 600);
    check({30'h0, fault}, 32'h1);
    check({31'h0, ssp[0]}, 32'h0);
    apb(fpc_pkg::ADDR_CMD, 1'b1, 32'h1);
    apb(fpc_pkg::ADDR_CTRL, 1'b1, 32'h0e);
    check({30'h0, fault}, 32'h0);
    press(130);
    wait_out(1'b1, 50);
    for (int i = 0; i < 5; i++) begin
      ctrl.drive(~(5'h10 >> i));
      repeat (200) @(posedge clock);
      if (i > 0) check({28'h0, pair_a}, 32'(i + 4));
      repeat (400) @(posedge clock);
      check({28'h0, pair_a}, 32'(i + 5));
    end
    ctrl.drive(5'h03);
    repeat (600) @(posedge clock);
    check({30'h0, fault}, 32'h1);
    ctrl.drive(5'h01);
    apb(fpc_pkg::ADDR_CTRL, 1'b1, 32'h4c);
    apb(fpc_pkg::ADDR_CMD, 1'b1, 32'h1);
    press(130);
    wait_out(1'b1, 50);
    dev_a <= 12'h0c8;
    repeat (50) @(posedge clock);
    check({31'h0, ssp[0]}, 32'h1);
    dev_a <= 12'h0c9;
    wait_out(1'b0, 50);
    apb(fpc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check({31'h0, q[19]}, 32'h1);
    dev_a <= 12'h000;
    apb(fpc_pkg::ADDR_CTRL, 1'b1, 32'h9e);
    apb(fpc_pkg::ADDR_CMD, 1'b1, 32'h1);
    ctrl.drive_b(5'h02);
    occ_b <= 10'h002;
    repeat (600) @(posedge clock);
    check({28'h0, pair_b}, 32'h1);
    check({30'h0, ssp}, 32'h3);
    repeat (400) @(posedge clock);
    check({30'h0, ssp}, 32'h1);
    check({30'h0, il}, 32'h2);
    occ_b <= 10'h000;
    dev_b <= 12'h0c9;
    repeat (10) @(posedge clock);
    check({30'h0, fault}, 32'h2);
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    stop_test();
  end
endmodule
